/* verif/pmcr_conv_model.sv */
// Converter model answering conversion requests
`default_nettype none
module pmcr_conv_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Request from the sequencer
    input wire logic conv_start,
    input wire pmcr_pkg::pmcr_chan_t conv_chan,
    // Bench controls
    input wire logic slow,
    input wire logic [11:0] outv_val,
    // Answer
    output logic conv_done,
    output logic [11:0] conv_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] wait_cnt;
    pmcr_pkg::pmcr_chan_t chan_held;
    // Data toggles outside the done pulse so a stale read is caught
    always @(posedge ref_clk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (reset) begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            conv_data <= 12'h5a5;
        end else if (busy) begin
            if (wait_cnt == 4'h0) begin
                busy <= 1'b0;
                conv_done <= 1'b1;
                if (chan_held == pmcr_pkg::PMCR_CH_OUTV) begin
                    conv_data <= outv_val;
                end else begin
                    conv_data <= 12'h0f0 ^ {10'h000, chan_held};
                end
            end else begin
                wait_cnt <= wait_cnt - 4'h1;
            end
        end else if (conv_start) begin
            busy <= 1'b1;
            chan_held <= conv_chan;
            wait_cnt <= slow ? 4'h6 : 4'h0;
        end
    end
endmodule
`default_nettype wire

/* verif/pmcr_regs_bench.sv */
// Self-checking bench for the power monitor control registers
`default_nettype none
module pmcr_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_write = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic cmd_ack_reg, cmd_nack_reg, conv_start, conv_done;
    logic [15:0] cmd_rdata_reg;
    pmcr_pkg::pmcr_chan_t conv_chan;
    logic [11:0] conv_data;
    logic mode, incl, range, running, pin_o, pin_oe_n;
    logic [2:0] avg;
    logic [6:0] status_flags = 7'h40;
    logic slow = 1'b0;
    logic [11:0] outv_val = 12'h123;
    int n_fail = 0;
    int checks = 0;
    pmcr_pkg::pmcr_chan_t chans[$];
    logic [15:0] rd;

    always #2.5 ref_clk = ~ref_clk;

    pmcr_regs DUT (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_ack_reg(cmd_ack_reg), .cmd_nack_reg(cmd_nack_reg),
        .cmd_rdata_reg(cmd_rdata_reg), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data),
        .sampling_mode_select(mode), .output_channel_include(incl),
        .voltage_range_select(range), .avg_select(avg),
        .monitor_running(running), .status_flags(status_flags),
        .secondary_output_pin_o(pin_o),
        .secondary_output_pin_oe_n(pin_oe_n));

    pmcr_conv_model conv (.ref_clk(ref_clk), .reset(reset),
        .conv_start(conv_start), .conv_chan(conv_chan), .slow(slow),
        .outv_val(outv_val), .conv_done(conv_done), .conv_data(conv_data));

    always @(posedge ref_clk) begin
        if (conv_start === 1'b1) begin
            chans.push_back(conv_chan);
        end
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One command; the answer stands only in the cycle after it is taken
    task automatic cmd(input logic wr, input logic [7:0] code,
                       input logic [15:0] wdata, input logic refuse = 1'b0);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = wdata;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        check("ack", {15'h0000, cmd_ack_reg}, {15'h0000, !refuse});
        check("nack", {15'h0000, cmd_nack_reg}, {15'h0000, refuse});
        rd = cmd_rdata_reg;
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
        cmd(1'b0, code, 16'h0000);
        check("rdata", rd, exp);
    endtask

    // Waits for the running flag to reach a level, bounded
    task automatic wait_run(input logic lvl);
        int i;
        for (i = 0; i < 4000 && running !== lvl; i++) begin
            @(negedge ref_clk);
        end
        if (running !== lvl) begin
            check("run wait", 16'h0000, 16'h0001);
            conclude();
        end
    endtask

    task automatic single(input int exp_n);
        chans.delete();
        cmd(1'b1, pmcr_pkg::PMCR_CMD_RUN, 16'h0001);
        wait_run(1'b1);
        wait_run(1'b0);
        rd_chk(pmcr_pkg::PMCR_CMD_RUN, 16'h0000);
        check("conv count", 16'(chans.size()), 16'(exp_n));
    endtask

    initial begin
        int i;
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        rd_chk(pmcr_pkg::PMCR_CMD_RUN, 16'h0001);
        rd_chk(pmcr_pkg::PMCR_CMD_PEAK, 16'h0000);
        rd_chk(pmcr_pkg::PMCR_CMD_SET, 16'h00af);
        rd_chk(pmcr_pkg::PMCR_CMD_ALERT, 16'h8000);
        check("mode", {15'h0000, mode}, 16'h0001);
        check("range", {15'h0000, range}, 16'h0001);
        check("avg", {13'h0000, avg}, 16'h0007);
        check("alert fet", {15'h0000, pin_oe_n}, 16'h0000);
        check("pin drive", {15'h0000, pin_o}, 16'h0000);
        check("running", {15'h0000, running}, 16'h0001);
        cmd(1'b1, 8'hd5, 16'h0000, 1'b1);
        check("nack unmapped", {15'h0000, cmd_nack_reg}, 16'h0001);
        check("ack unmapped", {15'h0000, cmd_ack_reg}, 16'h0000);
        cmd(1'b1, pmcr_pkg::PMCR_CMD_RUN, 16'hfffe);
        rd_chk(pmcr_pkg::PMCR_CMD_RUN, 16'h0000);
        repeat (20) @(negedge ref_clk);
        chans.delete();
        repeat (20) @(negedge ref_clk);
        check("idle convs", 16'(chans.size()), 16'h0000);
        check("running", {15'h0000, running}, 16'h0000);
        for (i = 0; i < 8; i++) begin
            cmd(1'b1, pmcr_pkg::PMCR_CMD_SET, 16'(8'h08 | i));
            @(negedge ref_clk);
            check("avg", {13'h0000, avg}, 16'(i));
        end
        // Reserved bits written the wrong way round
        cmd(1'b1, pmcr_pkg::PMCR_CMD_SET, 16'hff50);
        rd_chk(pmcr_pkg::PMCR_CMD_SET, 16'h0048);
        check("mode", {15'h0000, mode}, 16'h0000);
        check("incl", {15'h0000, incl}, 16'h0001);
        check("range", {15'h0000, range}, 16'h0000);
        single(3);
        check("ch0", 16'(chans[0]), 16'(pmcr_pkg::PMCR_CH_VIN));
        check("ch1", 16'(chans[1]), 16'(pmcr_pkg::PMCR_CH_CURR));
        check("ch2", 16'(chans[2]), 16'(pmcr_pkg::PMCR_CH_OUTV));
        rd_chk(pmcr_pkg::PMCR_CMD_PEAK, 16'h0123);
        outv_val = 12'h100;
        single(3);
        rd_chk(pmcr_pkg::PMCR_CMD_PEAK, 16'h0123);
        outv_val = 12'h456;
        single(3);
        rd_chk(pmcr_pkg::PMCR_CMD_PEAK, 16'h0456);
        cmd(1'b1, pmcr_pkg::PMCR_CMD_PEAK, 16'hfabc);
        rd_chk(pmcr_pkg::PMCR_CMD_PEAK, 16'h0abc);
        cmd(1'b1, pmcr_pkg::PMCR_CMD_PEAK, 16'h0000);
        rd_chk(pmcr_pkg::PMCR_CMD_PEAK, 16'h0000);
        cmd(1'b1, pmcr_pkg::PMCR_CMD_SET, 16'h0008);
        single(2);
        // Continuous mode with slow conversions and two samples
        slow = 1'b1;
        cmd(1'b1, pmcr_pkg::PMCR_CMD_SET, 16'h0089);
        chans.delete();
        cmd(1'b1, pmcr_pkg::PMCR_CMD_RUN, 16'h0001);
        repeat (200) @(negedge ref_clk);
        rd_chk(pmcr_pkg::PMCR_CMD_RUN, 16'h0001);
        check("cont convs", 16'(chans.size() > 8), 16'h0001);
        cmd(1'b1, pmcr_pkg::PMCR_CMD_RUN, 16'h0000);
        repeat (3) @(negedge ref_clk);
        check("stopped", {15'h0000, running}, 16'h0000);
        cmd(1'b1, pmcr_pkg::PMCR_CMD_ALERT, 16'hffff);
        rd_chk(pmcr_pkg::PMCR_CMD_ALERT, 16'hfe00);
        for (i = 0; i < 7; i++) begin
            cmd(1'b1, pmcr_pkg::PMCR_CMD_ALERT, 16'h0000);
            status_flags = 7'(1 << i);
            repeat (2) @(negedge ref_clk);
            check("masked", {15'h0000, pin_oe_n}, 16'h0001);
            cmd(1'b1, pmcr_pkg::PMCR_CMD_ALERT, 16'(1 << (9 + i)));
            @(negedge ref_clk);
            check("alert", {15'h0000, pin_oe_n}, 16'h0000);
            status_flags = 7'h00;
            repeat (2) @(negedge ref_clk);
            check("cleared", {15'h0000, pin_oe_n}, 16'h0001);
        end
        conclude();
    end
endmodule
`default_nettype wire

/* verilog/pmcr_peak.sv */
// Peak output-voltage capture
`default_nettype none
module pmcr_peak (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Host load, zero clears unless a new result lands in the same cycle
    input wire logic load,
    input wire logic [11:0] load_val,
    // New output-voltage result
    input wire logic sample_valid,
    input wire logic [11:0] sample,
    // Stored peak
    output logic [11:0] peak_reg
);
    logic bigger;
    assign bigger = sample_valid && (sample > peak_reg);

    // A result landing with a zero host write still counts; a nonzero write wins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            peak_reg <= pmcr_pkg::PMCR_PEAK_RST;
        end else if (load && !(load_val == 12'h000 && sample_valid)) begin
            peak_reg <= load_val;
        end else if (load) begin
            peak_reg <= sample;
        end else if (bigger) begin
            peak_reg <= sample;
        end
    end
endmodule
`default_nettype wire

/* verilog/pmcr_pkg.sv */
// Shared constants for the power monitor control registers
`default_nettype none
package pmcr_pkg;
    // Command codes
    localparam logic [7:0] PMCR_CMD_PEAK = 8'hd2;
    localparam logic [7:0] PMCR_CMD_RUN = 8'hd3;
    localparam logic [7:0] PMCR_CMD_SET = 8'hd4;
    localparam logic [7:0] PMCR_CMD_ALERT = 8'hd6;
    // Field positions
    localparam int PMCR_PEAK_W = 12;
    localparam int PMCR_RUN_BIT = 0;
    localparam int PMCR_MODE_BIT = 7;
    localparam int PMCR_OUTV_BIT = 6;
    localparam int PMCR_RANGE_BIT = 5;
    localparam int PMCR_RSV0_BIT = 4;
    localparam int PMCR_RSV1_BIT = 3;
    localparam int PMCR_AVG_LSB = 0;
    localparam int PMCR_AVG_W = 3;
    localparam int PMCR_MASK_LSB = 9;
    localparam int PMCR_MASK_W = 7;
    // Values after reset
    localparam logic [11:0] PMCR_PEAK_RST = 12'h000;
    localparam logic PMCR_RUN_RST = 1'b1;
    localparam logic [7:0] PMCR_SET_RST = 8'haf;
    localparam logic [15:0] PMCR_ALERT_RST = 16'h8000;
    // Cycles from a taken command to its answer
    localparam int PMCR_ANSWER_CYCLES = 1;
    // One sample, shifted up by the averaging code
    localparam logic [7:0] PMCR_AVG_ONE = 8'h01;
    typedef enum logic [1:0] {
        PMCR_CH_VIN = 2'h0,
        PMCR_CH_CURR = 2'h1,
        PMCR_CH_OUTV = 2'h2
    } pmcr_chan_t;
    typedef enum logic [1:0] {
        PMCR_S_IDLE = 2'h0,
        PMCR_S_REQ = 2'h1,
        PMCR_S_WAIT = 2'h3,
        PMCR_S_STEP = 2'h2
    } pmcr_state_t;
endpackage
`default_nettype wire

/* verilog/pmcr_regs.sv */
// Power monitor control registers, top level
//
// Summary of operation
// - Peak register at 0xD2, resets to zero; writing zero clears it unless an output-voltage result lands in the same cycle.
// - Peak bits 15:12 read zero; 11:0 hold largest output-voltage result.
// - Run-control byte at 0xD3 resets to 0x01; upper seven bits read zero.
// - Run bit set starts current and voltage sampling; clear means idle.
// - In single-shot mode the run bit clears after one full cycle.
// - In continuous mode sampling continues until host writes run bit zero.
// - Settings byte at 0xD4 resets to 0xAF.
// - Settings bit 7 picks single-shot (0) or continuous (1) mode.
// - Settings bit 6 adds the output voltage channel when set.
// - Settings bit 5 picks low 6 V or high 20 V range.
// - Averaging field picks none or 2 to 128 samples; default 128.
// - Alert enable word at 0xD6 resets to 0x8000.
// - Bit 15 enables alert on switch health fault, set from reset.
// - Bits 14 to 9 enable alert on six further status flags.
// - The alert output pin is pulled low by status flags that the enable mask lets through.
`default_nettype none
module pmcr_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Command port from the management link engine
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ack_reg,
    output logic cmd_nack_reg,
    output logic [15:0] cmd_rdata_reg,
    // Converter
    output logic conv_start,
    output pmcr_pkg::pmcr_chan_t conv_chan,
    input wire logic conv_done,
    input wire logic [11:0] conv_data,
    // Settings to the analog front end
    output logic sampling_mode_select,
    output logic output_channel_include,
    output logic voltage_range_select,
    output logic [2:0] avg_select,
    output logic monitor_running,
    // Status flags, bit 6 is the switch health fault
    input wire logic [6:0] status_flags,
    // Open-drain alert pin
    output logic secondary_output_pin_o,
    output logic secondary_output_pin_oe_n
);
    logic run_reg;
    logic [7:0] set_reg;
    logic [6:0] mask_reg;
    logic [11:0] peak_reg;
    logic cycle_done;
    logic wr_run;
    logic wr_set;
    logic wr_mask;
    logic wr_peak;
    logic [15:0] rd_next;
    logic [7:0] set_next;
    logic peak_sample;
    logic sampler_run;

    function automatic logic is_mapped(input logic [7:0] code);
        is_mapped = (code == pmcr_pkg::PMCR_CMD_PEAK) ||
                    (code == pmcr_pkg::PMCR_CMD_RUN) ||
                    (code == pmcr_pkg::PMCR_CMD_SET) ||
                    (code == pmcr_pkg::PMCR_CMD_ALERT);
    endfunction

    function automatic logic is_write(input logic v, input logic w,
                                      input logic [7:0] code,
                                      input logic [7:0] want);
        is_write = v && w && (code == want);
    endfunction

    assign wr_peak = is_write(cmd_valid, cmd_write, cmd_code,
                              pmcr_pkg::PMCR_CMD_PEAK);
    assign wr_run = is_write(cmd_valid, cmd_write, cmd_code,
                             pmcr_pkg::PMCR_CMD_RUN);
    assign wr_set = is_write(cmd_valid, cmd_write, cmd_code,
                             pmcr_pkg::PMCR_CMD_SET);
    assign wr_mask = is_write(cmd_valid, cmd_write, cmd_code,
                              pmcr_pkg::PMCR_CMD_ALERT);

    // Fixed reserved bits override whatever the host sends
    always_comb begin
        set_next = cmd_wdata[7:0];
        set_next[pmcr_pkg::PMCR_RSV0_BIT] = 1'b0;
        set_next[pmcr_pkg::PMCR_RSV1_BIT] = 1'b1;
    end

    // Run control
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            run_reg <= pmcr_pkg::PMCR_RUN_RST;
        end else if (wr_run) begin
            run_reg <= cmd_wdata[pmcr_pkg::PMCR_RUN_BIT];
        end else if (cycle_done &&
                     !set_reg[pmcr_pkg::PMCR_MODE_BIT]) begin
            run_reg <= 1'b0;
        end
    end

    // Settings are taken at any time; stopping first is the host's job
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            set_reg <= pmcr_pkg::PMCR_SET_RST;
        end else if (wr_set) begin
            set_reg <= set_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mask_reg <= pmcr_pkg::PMCR_ALERT_RST[15:9];
        end else if (wr_mask) begin
            mask_reg <= cmd_wdata[15:9];
        end
    end

    always_comb begin
        rd_next = 16'h0000;
        unique case (cmd_code)
            pmcr_pkg::PMCR_CMD_PEAK: rd_next[11:0] = peak_reg;
            pmcr_pkg::PMCR_CMD_RUN: rd_next[0] = run_reg;
            pmcr_pkg::PMCR_CMD_SET: rd_next[7:0] = set_reg;
            pmcr_pkg::PMCR_CMD_ALERT: rd_next[15:9] = mask_reg;
            default: rd_next = 16'h0000;
        endcase
    end

    // Answer one cycle after the command; unknown codes are refused
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmd_ack_reg <= 1'b0;
            cmd_nack_reg <= 1'b0;
            cmd_rdata_reg <= 16'h0000;
        end else begin
            cmd_ack_reg <= cmd_valid && is_mapped(cmd_code);
            cmd_nack_reg <= cmd_valid && !is_mapped(cmd_code);
            if (cmd_valid && !cmd_write) begin
                cmd_rdata_reg <= rd_next;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sampling_mode_select <=
                pmcr_pkg::PMCR_SET_RST[pmcr_pkg::PMCR_MODE_BIT];
            output_channel_include <=
                pmcr_pkg::PMCR_SET_RST[pmcr_pkg::PMCR_OUTV_BIT];
            voltage_range_select <=
                pmcr_pkg::PMCR_SET_RST[pmcr_pkg::PMCR_RANGE_BIT];
            avg_select <= pmcr_pkg::PMCR_SET_RST[2:0];
            monitor_running <= 1'b0;
        end else begin
            sampling_mode_select <= set_reg[pmcr_pkg::PMCR_MODE_BIT];
            output_channel_include <= set_reg[pmcr_pkg::PMCR_OUTV_BIT];
            voltage_range_select <= set_reg[pmcr_pkg::PMCR_RANGE_BIT];
            avg_select <= set_reg[2:0];
            monitor_running <= run_reg;
        end
    end

    // Alert pin pulls low while any enabled flag is set
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            secondary_output_pin_o <= 1'b0;
            secondary_output_pin_oe_n <= 1'b1;
        end else begin
            secondary_output_pin_o <= 1'b0;
            secondary_output_pin_oe_n <= ~|(status_flags & mask_reg);
        end
    end

    assign peak_sample = conv_done && (conv_chan == pmcr_pkg::PMCR_CH_OUTV);

    // Idle the sequencer on the self-clear edge, else it would launch
    // one stray conversion before the cleared run bit reaches it
    assign sampler_run = run_reg &&
                         !(cycle_done && !set_reg[pmcr_pkg::PMCR_MODE_BIT]);

    pmcr_peak u_peak (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(wr_peak),
        .load_val(cmd_wdata[11:0]),
        .sample_valid(peak_sample),
        .sample(conv_data),
        .peak_reg(peak_reg)
    );

    pmcr_sampler u_sampler (
        .ref_clk(ref_clk),
        .reset(reset),
        .run(sampler_run),
        .include_outv(set_reg[pmcr_pkg::PMCR_OUTV_BIT]),
        .avg_code(set_reg[2:0]),
        .conv_start_reg(conv_start),
        .chan_reg(conv_chan),
        .conv_done(conv_done),
        .cycle_done_reg(cycle_done)
    );

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    property p_peak_clear;
        wr_peak && cmd_wdata == 16'h0000 && !peak_sample
            |=> peak_reg == 12'h000;
    endproperty
    a_peak_clear: assert property (p_peak_clear)
        else $error("peak not cleared by zero write");

    property p_peak_read;
        cmd_valid && !cmd_write && cmd_code == pmcr_pkg::PMCR_CMD_PEAK
            |=> cmd_ack_reg && cmd_rdata_reg[15:12] == 4'h0
                && cmd_rdata_reg[11:0] == $past(peak_reg);
    endproperty
    a_peak_read: assert property (p_peak_read)
        else $error("peak read value wrong");

    property p_run_read;
        cmd_valid && !cmd_write && cmd_code == pmcr_pkg::PMCR_CMD_RUN
            |=> cmd_rdata_reg == {15'h0000, $past(run_reg)};
    endproperty
    a_run_read: assert property (p_run_read)
        else $error("run control read wrong");

    property p_idle;
        !run_reg && u_sampler.state_reg == pmcr_pkg::PMCR_S_IDLE
            |=> !conv_start [*2];
    endproperty
    a_idle: assert property (p_idle)
        else $error("conversion started while stopped");

    property p_single;
        cycle_done && !set_reg[pmcr_pkg::PMCR_MODE_BIT] && !wr_run
            |=> !run_reg ##1 !conv_start;
    endproperty
    a_single: assert property (p_single)
        else $error("single shot did not stop");

    property p_cont;
        cycle_done && set_reg[pmcr_pkg::PMCR_MODE_BIT] && !wr_run
            |=> run_reg ##[1:3] conv_start;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous mode stopped");

    property p_set_fixed;
        set_reg[pmcr_pkg::PMCR_RSV0_BIT] == 1'b0
            && set_reg[pmcr_pkg::PMCR_RSV1_BIT] == 1'b1;
    endproperty
    a_set_fixed: assert property (p_set_fixed)
        else $error("reserved settings bits changed");

    property p_set_write;
        wr_set |=> set_reg[7:5] == $past(cmd_wdata[7:5])
            && set_reg[2:0] == $past(cmd_wdata[2:0]);
    endproperty
    a_set_write: assert property (p_set_write)
        else $error("settings write lost");

    property p_alert;
        |(status_flags & mask_reg) && !wr_mask
            |=> !secondary_output_pin_oe_n && !secondary_output_pin_o;
    endproperty
    a_alert: assert property (p_alert)
        else $error("alert pin not driven");

    property p_peak_grow;
        peak_sample && !wr_peak && conv_data > peak_reg
            |=> peak_reg == $past(conv_data);
    endproperty
    a_peak_grow: assert property (p_peak_grow)
        else $error("peak missed a larger result");

    property p_peak_hold;
        !peak_sample && !wr_peak |=> $stable(peak_reg);
    endproperty
    a_peak_hold: assert property (p_peak_hold)
        else $error("peak changed without cause");

    property p_mask_reset;
        $fell(reset) |-> mask_reg == 7'h40 && set_reg == 8'haf
            && run_reg;
    endproperty
    a_mask_reset: assert property (@(posedge ref_clk) p_mask_reset)
        else $error("reset values wrong");

    property p_nack;
        cmd_valid && !is_mapped(cmd_code) |=> cmd_nack_reg && !cmd_ack_reg;
    endproperty
    a_nack: assert property (p_nack)
        else $error("unmapped code not refused");

    c_single: cover property (cycle_done && !set_reg[7]);
    c_cont: cover property (cycle_done ##[1:40] cycle_done);
    c_alert: cover property ($fell(secondary_output_pin_oe_n));
    c_peak: cover property (peak_sample && conv_data > peak_reg);
endmodule
`default_nettype wire

/* verilog/pmcr_sampler.sv */
// Conversion sequencer for one sampling cycle
`default_nettype none
module pmcr_sampler (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Settings
    input wire logic run,
    input wire logic include_outv,
    input wire logic [2:0] avg_code,
    // Converter handshake
    output logic conv_start_reg,
    output pmcr_pkg::pmcr_chan_t chan_reg,
    input wire logic conv_done,
    // One pulse per completed cycle
    output logic cycle_done_reg
);
    pmcr_pkg::pmcr_state_t state_reg;
    logic [7:0] count_reg;
    logic [7:0] needed;
    logic last_chan;

    // Code 0 gives one sample, code n gives two to the n
    assign needed = pmcr_pkg::PMCR_AVG_ONE << avg_code;
    assign last_chan = include_outv
        ? (chan_reg == pmcr_pkg::PMCR_CH_OUTV)
        : (chan_reg == pmcr_pkg::PMCR_CH_CURR);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= pmcr_pkg::PMCR_S_IDLE;
            chan_reg <= pmcr_pkg::PMCR_CH_VIN;
            count_reg <= 8'h00;
            conv_start_reg <= 1'b0;
            cycle_done_reg <= 1'b0;
        end else begin
            conv_start_reg <= 1'b0;
            cycle_done_reg <= 1'b0;
            unique case (state_reg)
                pmcr_pkg::PMCR_S_IDLE: begin
                    chan_reg <= pmcr_pkg::PMCR_CH_VIN;
                    count_reg <= 8'h00;
                    if (run) begin
                        state_reg <= pmcr_pkg::PMCR_S_REQ;
                    end
                end
                pmcr_pkg::PMCR_S_REQ: begin
                    conv_start_reg <= 1'b1;
                    state_reg <= pmcr_pkg::PMCR_S_WAIT;
                end
                pmcr_pkg::PMCR_S_WAIT: begin
                    if (conv_done) begin
                        count_reg <= count_reg + 8'h01;
                        state_reg <= pmcr_pkg::PMCR_S_STEP;
                    end
                end
                pmcr_pkg::PMCR_S_STEP: begin
                    // Stopping mid-cycle drops the partial cycle
                    if (!run) begin
                        state_reg <= pmcr_pkg::PMCR_S_IDLE;
                    end else if (count_reg != needed) begin
                        state_reg <= pmcr_pkg::PMCR_S_REQ;
                    end else if (!last_chan) begin
                        count_reg <= 8'h00;
                        chan_reg <= (chan_reg == pmcr_pkg::PMCR_CH_VIN)
                                    ? pmcr_pkg::PMCR_CH_CURR
                                    : pmcr_pkg::PMCR_CH_OUTV;
                        state_reg <= pmcr_pkg::PMCR_S_REQ;
                    end else begin
                        cycle_done_reg <= 1'b1;
                        state_reg <= pmcr_pkg::PMCR_S_IDLE;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire
